// *** src/sprg_pkg.sv ***
/*
 * Package for the supply and pushbutton reset generator: timing figures
 * and the cycle counts derived from them.
 * Assumes a 20 MHz system clock.
 */
package sprg_pkg;
   localparam int unsigned CLK_HZ            = 20_000_000;
   // Periods in milliseconds, least figures
   localparam int unsigned SHORT_RECOVERY_MS = 150;
   localparam int unsigned LONG_RECOVERY_MS  = 1200;
   localparam int unsigned MANUAL_PULSE_MS   = 150;
   localparam int unsigned DEBOUNCE_MS       = 150;
   // Supply dip tolerance, microseconds, and its depth scaling
   localparam int unsigned DIP_BASE_US       = 20;
   localparam int unsigned CNT_W             = 26;
   localparam logic [CNT_W-1:0] CNT_ZERO     = 26'h000_0000;
   localparam longint unsigned SHORT_RECOVERY_CYC = longint'(SHORT_RECOVERY_MS) * CLK_HZ / 1000;
   localparam longint unsigned LONG_RECOVERY_CYC  = longint'(LONG_RECOVERY_MS) * CLK_HZ / 1000;
   localparam longint unsigned MANUAL_PULSE_CYC   = longint'(MANUAL_PULSE_MS) * CLK_HZ / 1000;
   localparam longint unsigned DEBOUNCE_CYC       = longint'(DEBOUNCE_MS) * CLK_HZ / 1000;
   localparam longint unsigned DIP_BASE_CYC       = longint'(DIP_BASE_US) * CLK_HZ / 1000000;
   localparam logic [1:0] DEPTH_RESET = 2'h0;
endpackage

// *** src/sprg_timer_if.sv ***
/*
 * Interface between the generator and its down-counter timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface sprg_timer_if;
   logic                       load;
   logic [sprg_pkg::CNT_W-1:0] count;
   logic                       busy;
   modport ctl (output load, output count, input busy);
   modport tmr (input load, input count, output busy);
endinterface
`default_nettype wire

// *** src/sprg_timer.sv ***
/*
 * Loadable down-counter; busy while nonzero.
 * Assumes a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sprg_timer
   import sprg_pkg::*;
(
   input  wire logic  clock_in,
   input  wire logic  rstn_in,
   sprg_timer_if.tmr  tif
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   assign cnt_d    = tif.load ? tif.count : ((cnt_q != CNT_ZERO) ? cnt_q - 1'b1 : CNT_ZERO);
   assign tif.busy = (cnt_q != CNT_ZERO);

   always_ff @(posedge clock_in) begin
      if (!rstn_in) cnt_q <= CNT_ZERO;
      else          cnt_q <= cnt_d;
   end
endmodule // sprg_timer
`default_nettype wire

// *** src/sprg_gen.sv ***
/*
 * Supply and pushbutton reset generator: supply undervoltage with recovery
 * stretch, edge-triggered manual one-shot with release debounce.
 * Assumes undervoltage and manual inputs are asynchronous pins; one clock.
 */
// Function
// - Reset low on undervoltage or manual fall
// - Hold reset for recovery after supply returns
// - Manual fall fires fixed-length one-shot
// - Ignore falls during pulse or debounce
// - Debounce starts once input is high after the pulse ends
// - Re-arm after input high debounce period
// - Manual and debounce periods fixed across options
// - Brief dips tolerated, less when deeper
`timescale 1ns/1ps
`default_nettype none
module sprg_gen
   import sprg_pkg::*;
#(
   parameter int unsigned RECOVERY_SHORT_CYC = 32'(SHORT_RECOVERY_CYC),
   parameter int unsigned RECOVERY_LONG_CYC  = 32'(LONG_RECOVERY_CYC),
   parameter int unsigned MANUAL_CYC         = 32'(MANUAL_PULSE_CYC),
   parameter int unsigned DEBOUNCE_CYC_P     = 32'(DEBOUNCE_CYC),
   parameter int unsigned DIP_CYC            = 32'(DIP_BASE_CYC)
)(
   input  wire logic       clock_in,
   input  wire logic       rstn_in,
   input  wire logic       undervoltage_in,
   input  wire logic [1:0] dip_depth_in,
   input  wire logic       long_timeout_option_in,
   input  wire logic       manual_reset_input_n_in,
   output logic            reset_n_out,
   output logic            manual_armed_out
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] uv_sync_q;
   logic [1:0] mr_sync_q;
   logic       mr_prev_q;
   logic       uv_s;
   logic       mr_s;
   assign uv_s = uv_sync_q[1];
   assign mr_s = mr_sync_q[1];

   // ---------------------------------------------------------------
   // Supply path: dip filter and recovery stretch
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] dip_q;
   logic [CNT_W-1:0] dip_limit;
   logic             uv_valid_q;
   logic             uv_valid_d;
   logic             uv_fall;
   // Deeper dips cut the tolerated width by halves
   assign dip_limit  = CNT_W'(DIP_CYC) >> dip_depth_in;
   assign uv_valid_d = uv_s && (uv_valid_q || (dip_q + 1'b1 >= dip_limit));
   assign uv_fall    = uv_valid_q && !uv_valid_d;

   sprg_timer_if rec_if ();
   sprg_timer u_rec (.clock_in(clock_in), .rstn_in(rstn_in), .tif(rec_if));
   assign rec_if.load  = uv_valid_q;
   assign rec_if.count = long_timeout_option_in ? CNT_W'(RECOVERY_LONG_CYC)
                                                : CNT_W'(RECOVERY_SHORT_CYC);

   // ---------------------------------------------------------------
   // Manual path state machine
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {SPRG_ARMED, SPRG_PULSE, SPRG_WAIT_HIGH, SPRG_DEBOUNCE} sprg_mr_t;
   sprg_mr_t  st_q;
   sprg_mr_t  st_d;
   logic [CNT_W-1:0] pulse_q;
   logic [CNT_W-1:0] deb_q;
   logic      mr_fall;
   logic [CNT_W-1:0] pulse_d;
   logic [CNT_W-1:0] deb_d;
   logic      deb_enter;
   assign mr_fall = mr_prev_q && !mr_s;

   always_comb begin
      st_d = st_q;
      case (st_q)
         SPRG_ARMED:     if (mr_fall) st_d = SPRG_PULSE;
         // Falls here are simply not looked at
         SPRG_PULSE:     if (pulse_q == CNT_ZERO) st_d = SPRG_WAIT_HIGH;
         SPRG_WAIT_HIGH: if (mr_s) st_d = SPRG_DEBOUNCE;
         SPRG_DEBOUNCE: begin
            if (!mr_s) st_d = SPRG_WAIT_HIGH;
            else if (deb_q == CNT_ZERO) st_d = SPRG_ARMED;
         end
         default:        st_d = SPRG_ARMED;
      endcase
   end

   // Same length for both options; the option input is never looked at here
   assign pulse_d   = (st_q == SPRG_ARMED) ? CNT_W'(MANUAL_CYC - 1)
                      : ((pulse_q != CNT_ZERO) ? pulse_q - 1'b1 : CNT_ZERO);
   // Every new entry restarts the full window, so a bounce resets it
   assign deb_enter = (st_d == SPRG_DEBOUNCE) && (st_q != SPRG_DEBOUNCE);
   assign deb_d     = deb_enter ? CNT_W'(DEBOUNCE_CYC_P - 1)
                      : ((deb_q != CNT_ZERO) ? deb_q - 1'b1 : CNT_ZERO);

   logic mr_active;
   assign mr_active = (st_d == SPRG_PULSE);
   // Both sources OR together; each finishes on its own time
   logic rst_d;
   assign rst_d = !(uv_valid_d || uv_valid_q || rec_if.busy || mr_active);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Synchronisers leave reset at the idle levels of their pins,
   // so no false manual edge follows reset
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         uv_sync_q <= 2'h0;
         mr_sync_q <= 2'h3;
         mr_prev_q <= 1'b1;
      end else begin
         uv_sync_q <= {uv_sync_q[0], undervoltage_in};
         mr_sync_q <= {mr_sync_q[0], manual_reset_input_n_in};
         mr_prev_q <= mr_s;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         dip_q      <= CNT_ZERO;
         uv_valid_q <= 1'b0;
      end else begin
         dip_q      <= uv_s ? dip_q + 1'b1 : CNT_ZERO;
         uv_valid_q <= uv_valid_d;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         st_q    <= SPRG_ARMED;
         pulse_q <= CNT_ZERO;
         deb_q   <= CNT_ZERO;
      end else begin
         st_q    <= st_d;
         pulse_q <= pulse_d;
         deb_q   <= deb_d;
      end
   end

   // Outputs straight from flip-flops; reset is held low during rstn_in
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         reset_n_out      <= 1'b0;
         manual_armed_out <= 1'b0;
      end else begin
         reset_n_out      <= rst_d;
         manual_armed_out <= (st_d == SPRG_ARMED);
      end
   end

   // ---------------------------------------------------------------
   // Check helpers
   // ---------------------------------------------------------------
   // Pulse length counted on the side; a long repetition would choke the tools
   logic [CNT_W-1:0] chk_len_q;
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         chk_len_q <= CNT_ZERO;
      end else if (st_q == SPRG_PULSE) begin
         chk_len_q <= chk_len_q + 1'b1;
      end else begin
         chk_len_q <= CNT_ZERO;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_pulse_start;
      st_q == SPRG_ARMED && mr_fall;
   endsequence
   AST_UV_RESET: assert property (@(posedge clock_in) disable iff (!rstn_in)
      uv_valid_q |=> !reset_n_out) else $error("reset high during undervoltage");
   AST_MR_RESET: assert property (@(posedge clock_in) disable iff (!rstn_in)
      s_pulse_start |=> !reset_n_out) else $error("manual fall gave no reset");
   AST_RECOVERY: assert property (@(posedge clock_in) disable iff (!rstn_in)
      $fell(uv_valid_q) |=> rec_if.busy) else $error("recovery not started");
   AST_PULSE_FIXED: assert property (@(posedge clock_in) disable iff (!rstn_in)
      s_pulse_start |=> (st_q == SPRG_PULSE) [*8]) else $error("pulse cut short");
   AST_IGNORE: assert property (@(posedge clock_in) disable iff (!rstn_in)
      st_q == SPRG_WAIT_HIGH |=> st_q != SPRG_PULSE) else $error("fall not ignored");
   AST_DEB_START: assert property (@(posedge clock_in) disable iff (!rstn_in)
      st_q == SPRG_WAIT_HIGH && mr_s |=> st_q == SPRG_DEBOUNCE) else $error("no debounce");
   AST_REARM: assert property (@(posedge clock_in) disable iff (!rstn_in)
      st_q == SPRG_DEBOUNCE && mr_s && deb_q == CNT_ZERO |=> st_q == SPRG_ARMED)
      else $error("not rearmed");
   AST_OR: assert property (@(posedge clock_in) disable iff (!rstn_in)
      rec_if.busy && st_q == SPRG_PULSE |=> !reset_n_out) else $error("or broken");
   AST_DIP: assert property (@(posedge clock_in) disable iff (!rstn_in)
      $rose(uv_s) && dip_limit > 2 |-> !uv_valid_d) else $error("dip not filtered");

   sequence s_pulse_end;
      st_q == SPRG_PULSE && st_d != SPRG_PULSE;
   endsequence
   sequence s_deb_bounce;
      st_q == SPRG_DEBOUNCE && !mr_s;
   endsequence
   AST_PULSE_LEN: assert property (@(posedge clock_in) disable iff (!rstn_in)
      s_pulse_end |-> chk_len_q == CNT_W'(MANUAL_CYC - 1)) else $error("pulse length");
   AST_PULSE_LOAD: assert property (@(posedge clock_in) disable iff (!rstn_in)
      s_pulse_start |=> pulse_q == CNT_W'(MANUAL_CYC - 1)) else $error("pulse load");
   AST_DEB_RESTART: assert property (@(posedge clock_in) disable iff (!rstn_in)
      s_deb_bounce |=> st_q == SPRG_WAIT_HIGH) else $error("bounce not caught");
   AST_DEB_LOAD: assert property (@(posedge clock_in) disable iff (!rstn_in)
      deb_enter |=> deb_q == CNT_W'(DEBOUNCE_CYC_P - 1)) else $error("debounce load");
endmodule // sprg_gen
`default_nettype wire

// *** test/sprg_button.sv ***
/*
 * Pushbutton model on the manual reset pin, with contact bounce.
 * Assumes the bench holds press_in for at least 20 cycles (1 us).
 */
`timescale 1ns/1ps
`default_nettype none
module sprg_button (
   input  wire logic clock_in,
   input  wire logic press_in,
   output logic      pin_n_out
);
   logic       prev_q   = 1'b0;
   logic [2:0] bounce_q = 3'h0;
   initial pin_n_out = 1'b1;
   // Contacts chatter for six cycles on each change, as real switches do
   always @(posedge clock_in) begin
      prev_q <= press_in;
      if (press_in != prev_q) bounce_q <= 3'h6;
      else if (bounce_q != 3'h0) bounce_q <= bounce_q - 3'h1;
      pin_n_out <= (bounce_q != 3'h0) ? ~pin_n_out : ~prev_q;
   end
endmodule // sprg_button
`default_nettype wire

// *** test/test_sprg_gen.sv ***
/*
 * Self-checking bench for the reset generator, short parameter counts.
 * Assumes the pushbutton model drives the manual pin.
 */
`timescale 1ns/1ps
`default_nettype none
module test_sprg_gen;
   import sprg_pkg::*;
   localparam int REC_S = 40, REC_L = 80, MAN = 20, DEB = 30;
   logic       clock_in = 1'b0, rstn_in = 1'b0, uv = 1'b0, lopt = 1'b0, press = 1'b0;
   logic [1:0] depth    = 2'h0;
   logic       pin_n, reset_n, armed;
   int         failures = 0, samples_checked = 0, lows;
   initial forever #25 clock_in = ~clock_in;
   sprg_button i_btn (.clock_in(clock_in), .press_in(press), .pin_n_out(pin_n));
   sprg_gen #(.RECOVERY_SHORT_CYC(REC_S), .RECOVERY_LONG_CYC(REC_L), .MANUAL_CYC(MAN),
      .DEBOUNCE_CYC_P(DEB), .DIP_CYC(8)) i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
      .undervoltage_in(uv), .dip_depth_in(depth), .long_timeout_option_in(lopt),
      .manual_reset_input_n_in(pin_n), .reset_n_out(reset_n), .manual_armed_out(armed));
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask
   task automatic check(input logic [31:0] exp, input logic [31:0] act);
      samples_checked++;
      if (act !== exp) begin
         failures++;
         $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask
   // Counts low cycles of the reset output over a window
   task automatic watch(input int n);
      lows = 0;
      repeat (n) begin
         cyc(1);
         if (reset_n === 1'b0) lows++;
      end
   endtask
   // Held past the pulse; bounce on both edges must not retrigger
   task automatic press_long;
      press = 1'b1;
      fork cyc(40); watch(60); join
      press = 1'b0;
      check(MAN, lows);
      check(0, armed);
      cyc(DEB + 20);
      check(1, armed);
   endtask
   task automatic supply(input logic opt, input int rec);
      lopt = opt;
      uv   = 1'b1;
      cyc(20);
      check(0, reset_n);
      uv = 1'b0;
      cyc(rec - 4);
      check(0, reset_n);
      cyc(12);
      check(1, reset_n);
   endtask
   task automatic dip(input logic [1:0] d, input int exp_low);
      depth = d;
      uv    = 1'b1;
      cyc(4);
      uv = 1'b0;
      watch(60);
      check(exp_low, lows != 0);
   endtask
   task automatic overlap;
      lopt  = 1'b0;
      press = 1'b1;
      uv    = 1'b1;
      cyc(12);
      uv = 1'b0;
      cyc(28);
      check(0, reset_n);
      press = 1'b0;
      cyc(30);
      check(1, reset_n);
      cyc(DEB + 10);
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      cyc(2);
      rstn_in = 1'b1;
      cyc(3);
      check(1, armed);
      press_long();
      press_long();
      supply(1'b0, REC_S);
      supply(1'b1, REC_L);
      dip(2'h0, 0);
      dip(2'h3, 1);
      cyc(REC_S + 10);
      overlap();
      tally_and_finish();
   end
   initial begin
      #(50 * 3000);
      failures++;
      tally_and_finish();
   end
endmodule // test_sprg_gen
`default_nettype wire
